/* verilog/aal_pkg.sv */
// shared constants and types of the alarm annunciator
package aal_pkg;

    // register bus geometry
    localparam int AAL_AW = 8;
    localparam int AAL_DW = 32;

    // register byte offsets
    localparam logic [7:0] AAL_CTRL_OFS  = 8'h00;
    localparam logic [7:0] AAL_AUD_OFS   = 8'h04;
    localparam logic [7:0] AAL_KEY_OFS   = 8'h08;
    localparam logic [7:0] AAL_SHED_OFS  = 8'h0C;
    localparam logic [7:0] AAL_ROUTE_OFS = 8'h10;
    localparam logic [7:0] AAL_STAT_OFS  = 8'h14;
    localparam logic [7:0] AAL_ADDR_OFS  = 8'h18;

    // field positions
    localparam int AAL_CTRL_MODE_BIT = 0;
    localparam int AAL_CTRL_PREF_BIT = 1;
    localparam int AAL_KEY_ALARM_BIT = 0;
    localparam int AAL_KEY_RESET_BIT = 1;
    localparam int AAL_SHED_EN_BIT   = 4;

    // widths of the function groups
    localparam int AAL_NFAULT = 8;
    localparam int AAL_NAUD   = 9;
    localparam int AAL_NEXP   = 8;
    localparam int AAL_NPROG  = 4;
    localparam int AAL_NPIN   = 19;

    // reset values
    localparam logic [8:0] AAL_AUD_RST   = 9'h1FF;
    localparam logic [4:0] AAL_SHED_RST  = 5'h00;
    localparam logic [3:0] AAL_ROUTE_RST = 4'h0;

    // load shed source codes
    localparam logic [3:0] AAL_SHED_MAIN1 = 4'h0;
    localparam logic [3:0] AAL_SHED_MAIN2 = 4'h1;
    localparam logic [3:0] AAL_SHED_EXP0  = 4'h2;

    // accessory bus addresses
    localparam logic [3:0] AAL_OWN_ADDR    = 4'h5;
    localparam logic [3:0] AAL_EXP_ADDR_LO = 4'h1;
    localparam logic [3:0] AAL_EXP_ADDR_HI = 4'h4;
    localparam logic [3:0] AAL_BAT_ADDR    = 4'h6;

    // timing
    localparam int AAL_CLK_HZ       = 25_000_000;
    localparam int AAL_DEB_TIME_US  = 10_000;
    localparam int AAL_DEB_CYCLES   = AAL_DEB_TIME_US * (AAL_CLK_HZ / 1_000_000);

    // bus responses
    localparam logic [1:0] AAL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AAL_RESP_SLVERR = 2'h2;

    // silence latch states
    typedef enum logic [1:0] {
        AAL_IDLE   = 2'b00,
        AAL_SOUND  = 2'b01,
        AAL_MENU   = 2'b10,
        AAL_SILENT = 2'b11
    } aal_state_t;

    // software controls
    typedef struct packed {
        logic pref_emerg;
        logic emerg_mode;
    } aal_ctrl_t;

    // raw contact and switch pins
    typedef struct packed {
        logic [3:0] dip;
        logic [1:0] main_in;
        logic [7:0] exp_in;
        logic       at_emerg;
        logic       at_normal;
        logic       start_req;
        logic       wire_open;
        logic       wire_short;
    } aal_pins_t;

endpackage

/* verilog/aal_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
// synchroniser and debouncer for a group of contact inputs
module aal_debounce #(
    parameter int W   = 1,
    parameter int CNT = 4
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // raw pins and filtered levels
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] d_out
);

    localparam int CW = $clog2(CNT + 1);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic          s1_reg;   // first sync stage
            logic          s2_reg;   // second sync stage
            logic [CW-1:0] cnt_reg;  // stable time counter
            logic          q_reg;    // accepted level

            // two stages before any logic looks at the pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= d_in[i];
                    s2_reg <= s1_reg;
                end
            end

            // accept a new level once it has held long enough
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_reg <= '0;
                    q_reg   <= 1'b0;
                end else if (s2_reg == q_reg) begin
                    cnt_reg <= '0;
                end else if (cnt_reg == CW'(CNT - 1)) begin
                    cnt_reg <= '0;
                    q_reg   <= s2_reg;
                end else begin
                    cnt_reg <= cnt_reg + CW'(1);
                end
            end

            assign d_out[i] = q_reg;
        end
    endgenerate

endmodule
`default_nettype wire

/* verilog/aal_top.sv */
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module aal_top
    import aal_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = AAL_DEB_CYCLES
) (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address
    input  wire logic [AAL_AW-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    // axi4-lite write data
    input  wire logic [AAL_DW-1:0]     s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [AAL_AW-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    // axi4-lite read data
    output var  logic [AAL_DW-1:0]     s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // fault events from controller logic
    input  wire logic [AAL_NFAULT-1:0] fault_events,
    // raw pins
    input  wire aal_pins_t             pins,
    // annunciation outputs
    output var  logic                  horn,
    output var  logic                  ext_alarm_no,
    output var  logic                  ext_alarm_nc,
    output var  logic                  emerg_led,
    output var  logic                  alarm_softkey,
    output var  logic                  silenced_disp,
    output var  logic                  alert_led,
    output var  logic [AAL_NPROG-1:0]  prog_out,
    // configuration outputs
    output var  logic                  pref_enable,
    output var  logic                  pref_emergency,
    output var  logic                  supervised_en,
    output var  logic [3:0]            bus_addr,
    // transfer and engine start
    output var  logic                  force_off,
    output var  logic                  gen_start,
    output var  logic                  start_fault
);

    // filtered pins
    aal_pins_t                 pin_q;          // debounced pin levels
    // software registers
    aal_ctrl_t                 ctrl_reg;       // mode and preference
    logic [AAL_NAUD-1:0]       aud_en_reg;     // audible enable mask
    logic [4:0]                shed_reg;       // load shed source
    logic [AAL_NPROG-1:0]      route_reg;      // silenced routing
    logic                      key_alarm_reg;  // alarm softkey pulse
    logic                      key_reset_reg;  // reset key pulse
    // bus slave state
    logic                      aw_full_reg;    // address held
    logic                      w_full_reg;     // data held
    logic [AAL_AW-1:0]         aw_addr_reg;    // held write address
    logic [AAL_DW-1:0]         w_data_reg;     // held write data
    logic [3:0]                w_strb_reg;     // held byte enables
    logic [AAL_DW-1:0]         wmask;          // byte lanes as bits
    logic                      wr_fire;        // write commits now
    // annunciation state
    aal_state_t                state_reg;      // silence latch
    aal_state_t                state_next;     // next latch state
    logic                      nonpref_pos;    // switch off preference
    logic                      start_flt;      // wiring fault seen
    logic [AAL_NAUD-1:0]       func_vec;       // alarm functions
    logic                      alarm_cond;     // any selected alarm
    logic                      shed_in;        // selected shed input
    logic [AAL_DW-1:0]         rd_word;        // read mux result
    logic                      rd_ok;          // read address mapped

    // contacts and switches pass sync and debounce
    aal_debounce #(
        .W   (AAL_NPIN),
        .CNT (DEBOUNCE_CYCLES)
    ) u_deb (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d_in    (pins),
        .d_out   (pin_q)
    );

    // ---------------- register bus ----------------

    // write commits once address and data are both held
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;

    // byte enables spread to bit lanes
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                    {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    // write address channel, taken independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            aw_addr_reg   <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_full_reg   <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel, taken independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg   <= 1'b0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_full_reg   <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // write response after both halves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AAL_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // unmapped or read-only offsets answer slverr
            case (aw_addr_reg)
                AAL_CTRL_OFS, AAL_AUD_OFS, AAL_KEY_OFS,
                AAL_SHED_OFS, AAL_ROUTE_OFS: s_axi_bresp <= AAL_RESP_OKAY;
                default:                     s_axi_bresp <= AAL_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= '0;
            aud_en_reg <= AAL_AUD_RST;
            shed_reg   <= AAL_SHED_RST;
            route_reg  <= AAL_ROUTE_RST;
        end else if (wr_fire) begin
            case (aw_addr_reg)
                // mode and preferred source choice
                AAL_CTRL_OFS: begin
                    ctrl_reg <= aal_ctrl_t'((w_data_reg[1:0] & wmask[1:0])
                                            | (ctrl_reg & ~wmask[1:0]));
                end
                // one enable per alarm function
                AAL_AUD_OFS: begin
                    aud_en_reg <= (w_data_reg[AAL_NAUD-1:0] & wmask[AAL_NAUD-1:0])
                                | (aud_en_reg & ~wmask[AAL_NAUD-1:0]);
                end
                // load shed input assignment
                AAL_SHED_OFS: begin
                    shed_reg <= (w_data_reg[4:0] & wmask[4:0])
                              | (shed_reg & ~wmask[4:0]);
                end
                // silenced condition routing
                AAL_ROUTE_OFS: begin
                    route_reg <= (w_data_reg[AAL_NPROG-1:0] & wmask[AAL_NPROG-1:0])
                               | (route_reg & ~wmask[AAL_NPROG-1:0]);
                end
                default: begin
                end
            endcase
        end
    end

    // key presses arrive as one-cycle pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_alarm_reg <= 1'b0;
            key_reset_reg <= 1'b0;
        end else begin
            key_alarm_reg <= wr_fire && (aw_addr_reg == AAL_KEY_OFS)
                             && w_strb_reg[0] && w_data_reg[AAL_KEY_ALARM_BIT];
            key_reset_reg <= wr_fire && (aw_addr_reg == AAL_KEY_OFS)
                             && w_strb_reg[0] && w_data_reg[AAL_KEY_RESET_BIT];
        end
    end

    // read mux
    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            AAL_CTRL_OFS:  rd_word[1:0]            = ctrl_reg;
            AAL_AUD_OFS:   rd_word[AAL_NAUD-1:0]   = aud_en_reg;
            AAL_KEY_OFS:   rd_word                 = '0;
            AAL_SHED_OFS:  rd_word[4:0]            = shed_reg;
            AAL_ROUTE_OFS: rd_word[AAL_NPROG-1:0]  = route_reg;
            // live block state
            AAL_STAT_OFS: begin
                rd_word[1:0]   = state_reg;
                rd_word[2]     = horn;
                rd_word[3]     = alarm_cond;
                rd_word[4]     = start_fault;
                rd_word[5]     = force_off;
                rd_word[6]     = pref_enable;
                rd_word[7]     = supervised_en;
                rd_word[11:8]  = pin_q.dip;
                rd_word[12]    = gen_start;
            end
            // accessory bus addresses
            AAL_ADDR_OFS: begin
                rd_word[3:0]   = AAL_OWN_ADDR;
                rd_word[7:4]   = AAL_EXP_ADDR_LO;
                rd_word[11:8]  = AAL_EXP_ADDR_HI;
                rd_word[15:12] = AAL_BAT_ADDR;
            end
            default:       rd_ok = 1'b0;
        endcase
    end

    // read channel, one access at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= AAL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? AAL_RESP_OKAY : AAL_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------- annunciation ----------------

    // non-preferred position: normal side when emergency is preferred
    assign nonpref_pos = (pin_q.dip[0] && ctrl_reg.pref_emerg) ? pin_q.at_normal
                                                               : pin_q.at_emerg;

    // wiring fault is an open or a short
    assign start_flt = pin_q.wire_open || pin_q.wire_short;

    // start wiring fault is the ninth alarm function
    assign func_vec = {start_flt, fault_events};

    // selected functions, plus position in emergency mode
    assign alarm_cond = (|(func_vec & aud_en_reg))
                      || (ctrl_reg.emerg_mode && nonpref_pos);

    // silence latch transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            // waiting for an alarm
            AAL_IDLE: begin
                if (alarm_cond) state_next = AAL_SOUND;
            end
            // horn on; only a key sequence or the fault clearing stops it
            AAL_SOUND: begin
                if (!alarm_cond)        state_next = AAL_IDLE;
                else if (key_alarm_reg) state_next = AAL_MENU;
            end
            // alarm key taken, awaiting reset key
            AAL_MENU: begin
                if (!alarm_cond)        state_next = AAL_IDLE;
                else if (key_reset_reg) state_next = AAL_SILENT;
            end
            // silenced until the fault clears
            AAL_SILENT: begin
                if (!alarm_cond) state_next = AAL_IDLE;
            end
        endcase
    end

    // latch state
    always_ff @(posedge aclk) begin
        if (!aresetn) state_reg <= AAL_IDLE;
        else          state_reg <= state_next;
    end

    // horn, display and lamps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            horn          <= 1'b0;
            alarm_softkey <= 1'b0;
            silenced_disp <= 1'b0;
            alert_led     <= 1'b0;
            emerg_led     <= 1'b0;
            prog_out      <= '0;
        end else begin
            horn          <= (state_next == AAL_SOUND)
                          || (state_next == AAL_MENU);
            alarm_softkey <= (state_next == AAL_SOUND);
            silenced_disp <= (state_next == AAL_SILENT);
            alert_led     <= (state_next == AAL_SILENT);
            emerg_led     <= ctrl_reg.emerg_mode && nonpref_pos;
            prog_out      <= route_reg & {AAL_NPROG{state_next == AAL_SILENT}};
        end
    end

    // changeover contact for the external alarm
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_alarm_no <= 1'b0;
            ext_alarm_nc <= 1'b1;
        end else begin
            ext_alarm_no <= alarm_cond;
            ext_alarm_nc <= !alarm_cond;
        end
    end

    // ---------------- configuration switches ----------------

    // switches 3 and 4 drive no output; only the status word shows them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pref_enable    <= 1'b0;
            pref_emergency <= 1'b0;
            supervised_en  <= 1'b0;
            bus_addr       <= AAL_OWN_ADDR;
        end else begin
            pref_enable    <= pin_q.dip[0];
            pref_emergency <= pin_q.dip[0] && ctrl_reg.pref_emerg;
            supervised_en  <= pin_q.dip[1];
            bus_addr       <= AAL_OWN_ADDR;
        end
    end

    // ---------------- load shed and engine start ----------------

    // pick the assigned load shed input
    always_comb begin
        shed_in = 1'b0;
        if (shed_reg[3:0] == AAL_SHED_MAIN1) begin
            shed_in = pin_q.main_in[0];
        end else if (shed_reg[3:0] == AAL_SHED_MAIN2) begin
            shed_in = pin_q.main_in[1];
        end else if (shed_reg[3:0] < AAL_SHED_EXP0 + 4'(AAL_NEXP)) begin
            shed_in = pin_q.exp_in[3'(shed_reg[3:0] - AAL_SHED_EXP0)];
        end
    end

    // forced transfer and start output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            force_off   <= 1'b0;
            gen_start   <= 1'b0;
            start_fault <= 1'b0;
        end else begin
            force_off   <= shed_reg[AAL_SHED_EN_BIT] && shed_in;
            gen_start   <= pin_q.start_req || start_flt;
            start_fault <= start_flt;
        end
    end

endmodule
`default_nettype wire

/* verification/aal_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module aal_chk (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // annunciation and config outputs
    input wire logic       horn,
    input wire logic       ext_alarm_no,
    input wire logic       ext_alarm_nc,
    input wire logic       alarm_softkey,
    input wire logic       silenced_disp,
    input wire logic       alert_led,
    input wire logic [3:0] prog_out,
    input wire logic       pref_enable,
    input wire logic       pref_emergency,
    input wire logic [3:0] bus_addr,
    input wire logic       gen_start,
    input wire logic       start_fault
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    nc_inverse_a: assert property (ext_alarm_nc == !ext_alarm_no) else $error("legs");
    horn_contact_a: assert property (horn |-> ext_alarm_no) else $error("horn");
    fixed_addr_a: assert property (bus_addr == 4'h5) else $error("addr");
    pref_gate_a: assert property (pref_emergency |-> pref_enable) else $error("pref");
    silence_lamps_a: assert property (silenced_disp |-> !horn && alert_led) else $error("sil");
    route_gate_a: assert property (prog_out != 4'h0 |-> silenced_disp) else $error("route");
    horn_hold_a: assert property ($fell(horn) |-> silenced_disp || !ext_alarm_no) else $error("hold");
    softkey_horn_a: assert property (alarm_softkey |-> horn) else $error("key");
    start_out_a: assert property (start_fault |-> gen_start) else $error("start");
    cover property (silenced_disp);
    cover property (horn && alarm_softkey);
    cover property (start_fault);
endmodule
bind aal_top aal_chk u_chk (.aclk, .aresetn, .horn, .ext_alarm_no, .ext_alarm_nc, .alarm_softkey,
    .silenced_disp, .alert_led, .prog_out, .pref_enable, .pref_emergency, .bus_addr,
    .gen_start, .start_fault);
`default_nettype wire

/* verification/aal_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
// field contacts: every change chatters for a few cycles before it settles
module aal_field_model
    import aal_pkg::*;
(
    // clock
    input  wire logic      aclk,
    // wanted levels and bouncing pins
    input  wire aal_pins_t want,
    output var  aal_pins_t pins = '0
);
    logic [1:0] cnt  = 2'h0; // chatter cycles left
    aal_pins_t  last = '0;   // previous wanted level
    aal_pins_t  old  = '0;   // level before the change
    // restart chatter on change, show old level on odd counts
    always @(posedge aclk) begin
        last <= want;
        if (want != last) old <= last;
        cnt  <= (want != last) ? 2'h3 : (cnt != 2'h0) ? cnt - 2'h1 : 2'h0;
        pins <= cnt[0] ? old : want;
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aal_pkg::*;
    // clock, reset and bus master
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fault_events = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hF, prog_out, bus_addr;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    // field side and outputs
    aal_pins_t want = '0, pins;
    logic horn, ext_alarm_no, ext_alarm_nc, emerg_led, alarm_softkey, silenced_disp, alert_led;
    logic pref_enable, pref_emergency, supervised_en, force_off, gen_start, start_fault;
    int num_errors = 0, samples_checked = 0;
    always #20 aclk = ~aclk;
    aal_top #(.DEBOUNCE_CYCLES(4)) u_dut (.*);
    aal_field_model u_fld (.aclk(aclk), .want(want), .pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // wait n edges, then let their updates land
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // bounded bus waits end the run when used up
    task automatic hang(input int n);
        if (n >= 64) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 64);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hang(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 64);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        hang(n);
    endtask
    task automatic t_reset;
        tick(1);
        chk({horn, ext_alarm_nc, prog_out, bus_addr}, 10'h105);
        rd(AAL_AUD_OFS); chk(rv, 32'h1FF);
        rd(AAL_ADDR_OFS); chk(rv, 32'h6415);
        rd(8'h1C); chk(rr, AAL_RESP_SLVERR);
        wr(AAL_STAT_OFS, 32'hF); chk(rr, AAL_RESP_SLVERR);
        $display("reset test done");
    endtask
    task automatic t_mask;
        wr(AAL_AUD_OFS, 32'h1FE);
        @(posedge aclk) fault_events <= 8'h01;
        tick(3); chk(horn, 1'b0);
        @(posedge aclk) fault_events <= 8'h02;
        tick(3); chk(horn, 1'b1);
        @(posedge aclk) fault_events <= 8'h00;
        wr(AAL_AUD_OFS, 32'h1FF); // all nine functions selected again
        $display("mask test done");
    endtask
    task automatic t_silence;
        wr(AAL_ROUTE_OFS, 32'hA);
        @(posedge aclk) fault_events <= 8'h01;
        tick(2); chk({horn, alarm_softkey, ext_alarm_no, ext_alarm_nc}, 4'hE);
        wr(AAL_KEY_OFS, 32'h2); tick(100); chk(horn, 1'b1);
        wr(AAL_KEY_OFS, 32'h1); tick(3); chk({horn, alarm_softkey}, 2'b10);
        wr(AAL_KEY_OFS, 32'h2); tick(3);
        chk({horn, silenced_disp, alert_led, prog_out}, 7'h3A);
        @(posedge aclk) fault_events <= 8'h00;
        tick(2); chk({silenced_disp, ext_alarm_nc}, 2'b01);
        @(posedge aclk) fault_events <= 8'h01;
        tick(2); chk(horn, 1'b1);
        @(posedge aclk) fault_events <= 8'h00;
        $display("silence test done");
    endtask
    task automatic t_emerg;
        wr(AAL_CTRL_OFS, 32'h1);
        @(posedge aclk) want.at_emerg <= 1'b1;
        tick(20); chk({horn, emerg_led, pref_enable}, 3'b110);
        @(posedge aclk) want.dip <= 4'hF; // all four switches on, preference and supervised included
        wr(AAL_CTRL_OFS, 32'h3); tick(20);
        chk({horn, pref_enable, pref_emergency, supervised_en}, 4'h7);
        @(posedge aclk) want.at_normal <= 1'b1;
        tick(20); chk(horn, 1'b1);
        @(posedge aclk) want <= '0;
        wr(AAL_CTRL_OFS, 32'h0); tick(20);
        $display("emergency test done");
    endtask
    task automatic t_shed;
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk) {want.exp_in, want.main_in} <= 10'h1 << i;
            wr(AAL_SHED_OFS, 32'h10 + i); tick(20); chk(force_off, 1'b1);
        end
        wr(AAL_SHED_OFS, 32'h9); tick(3); chk(force_off, 1'b0);
        @(posedge aclk) want <= '0;
        $display("shed test done");
    endtask
    task automatic t_start;
        @(posedge aclk) want.start_req <= 1'b1;
        tick(20); chk({gen_start, start_fault, horn}, 3'b100);
        @(posedge aclk) want <= '{wire_open: 1'b1, default: '0};
        tick(20); chk({gen_start, start_fault, horn}, 3'b111);
        @(posedge aclk) want <= '{wire_short: 1'b1, default: '0};
        tick(20); chk({gen_start, start_fault, horn}, 3'b111);
        @(posedge aclk) want <= '0;
        $display("start test done");
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mask();
        t_silence();
        t_emerg();
        t_shed();
        t_start();
        report_and_stop();
    end
endmodule
`default_nettype wire
